// ### rtl/spinit_defs.svh
// Constants for the secondary interrupt unit initialization block
`ifndef SPINIT_DEFS_SVH
`define SPINIT_DEFS_SVH
`define SPINIT_PORT_EVEN      8'hA0
`define SPINIT_PORT_ODD       8'hA1
`define SPINIT_W1_START_BIT   4
`define SPINIT_W1_LEVEL_BIT   3
`define SPINIT_W2_VEC_HI      7
`define SPINIT_W2_VEC_LO      3
`define SPINIT_W4_FNEST_BIT   4
`define SPINIT_W4_AEOI_BIT    1
`define SPINIT_WORD_RESET     8'h00
`define SPINIT_W4_RESET       8'h02
`define SPINIT_VECTOR_RESET   8'h00
`define SPINIT_PULSE_RESET    1'h0
`endif

// ### rtl/spinit_pkg.sv
// Types for the secondary interrupt unit initialization block
package spinit_pkg;
  typedef enum logic [3:0] {
    SPINIT_OPER = 4'h1,
    SPINIT_W2   = 4'h2,
    SPINIT_W3   = 4'h4,
    SPINIT_W4   = 4'h8
  } spinit_state_type;
endpackage : spinit_pkg

// ### rtl/spinit_wordreg.sv
// Byte-wide configuration word register with write strobe
`timescale 1ns/1ps
`default_nettype none
module spinit_wordreg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Write side
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  // Stored word
  output logic      [7:0] o_q
);
  logic [7:0] word_ff;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      word_ff <= RESET_VAL;
    end else if (i_we) begin
      word_ff <= i_wdata;
    end
  end

  assign o_q = word_ff;
endmodule : spinit_wordreg
`default_nettype wire

// ### rtl/spinit_secondary_interrupt_unit.sv
// Initialization sequencer and config store of the secondary interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "spinit_defs.svh"
module spinit_secondary_interrupt_unit
  import spinit_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Host I/O port access
  input  wire logic       i_io_wr,
  input  wire logic [7:0] i_io_addr,
  input  wire logic [7:0] i_io_wdata,
  // Acknowledge interface
  input  wire logic       i_ack_second,
  input  wire logic [2:0] i_resolver_level,
  // Configuration out
  output logic            o_init_busy,
  output logic            o_level_trigger,
  output logic [4:0]      o_vector_base,
  output logic [7:0]      o_cascade_word,
  output logic            o_auto_eoi_en,
  output logic            o_full_nest_en,
  output logic [7:0]      o_ack_vector,
  output logic            o_auto_eoi_pulse
);

  // Sequencer state
  spinit_state_type state_ff;
  spinit_state_type nxt_state;

  // Stored words
  logic [7:0]       w1_q;
  logic [7:0]       w2_q;
  logic [7:0]       w3_q;
  logic [7:0]       w4_q;

  // Acknowledge path
  logic [7:0]       ack_vector_ff;
  logic [7:0]       nxt_ack_vector;
  logic             aeoi_ff;
  logic             nxt_aeoi;

  // Port and word decode
  logic             even_wr;
  logic             odd_wr;
  logic             start_hit;
  logic             w1_we;
  logic             w2_we;
  logic             w3_we;
  logic             w4_we;
  logic             aeoi_en;
  logic             in_oper;

  // Strobed write to one port
  function automatic logic port_hit(
    input logic       wr,
    input logic [7:0] addr,
    input logic [7:0] port
  );
    port_hit = wr && (addr == port);
  endfunction : port_hit

  // Odd-port write landing on the word being waited for
  function automatic logic word_hit(
    input logic             hit,
    input spinit_state_type cur,
    input spinit_state_type want
  );
    word_hit = hit && (cur == want);
  endfunction : word_hit

  // Upper five vector bits held in word two
  function automatic logic [4:0] vec_upper(
    input logic [7:0] word
  );
    vec_upper = word[`SPINIT_W2_VEC_HI:`SPINIT_W2_VEC_LO];
  endfunction : vec_upper

  // Following position in the initialization sequence
  function automatic spinit_state_type next_word(
    input spinit_state_type cur
  );
    unique case (cur)
      SPINIT_OPER: next_word = SPINIT_OPER;
      SPINIT_W2:   next_word = SPINIT_W3;
      SPINIT_W3:   next_word = SPINIT_W4;
      SPINIT_W4:   next_word = SPINIT_OPER;
      default:     next_word = SPINIT_OPER;
    endcase
  endfunction : next_word

  // Write decode
  assign even_wr   = port_hit(i_io_wr, i_io_addr, `SPINIT_PORT_EVEN);
  assign odd_wr    = port_hit(i_io_wr, i_io_addr, `SPINIT_PORT_ODD);
  assign start_hit = i_io_wdata[`SPINIT_W1_START_BIT];
  assign w1_we     = even_wr && start_hit;
  assign w2_we     = word_hit(odd_wr, state_ff, SPINIT_W2);
  assign w3_we     = word_hit(odd_wr, state_ff, SPINIT_W3);
  assign w4_we     = word_hit(odd_wr, state_ff, SPINIT_W4);
  assign in_oper   = (state_ff == SPINIT_OPER);

  // Word one restarts the sequence from any state
  always_comb begin
    nxt_state = state_ff;
    if (w1_we) begin
      nxt_state = SPINIT_W2;
    end else begin
      unique case (state_ff)
        SPINIT_OPER: begin
          nxt_state = SPINIT_OPER;
        end
        SPINIT_W2: begin
          if (w2_we) begin
            nxt_state = next_word(state_ff);
          end
        end
        SPINIT_W3: begin
          if (w3_we) begin
            nxt_state = next_word(state_ff);
          end
        end
        SPINIT_W4: begin
          if (w4_we) begin
            nxt_state = next_word(state_ff);
          end
        end
        default: begin
          nxt_state = SPINIT_OPER;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff <= SPINIT_OPER;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Word registers; write enables differ, and word four also has its own reset value
  spinit_wordreg #(.RESET_VAL(`SPINIT_WORD_RESET)) u_w1 (
    .i_clk   (i_clk),
    .i_resetn(i_resetn),
    .i_we    (w1_we),
    .i_wdata (i_io_wdata),
    .o_q     (w1_q)
  );

  spinit_wordreg #(.RESET_VAL(`SPINIT_WORD_RESET)) u_w2 (
    .i_clk   (i_clk),
    .i_resetn(i_resetn),
    .i_we    (w2_we),
    .i_wdata (i_io_wdata),
    .o_q     (w2_q)
  );

  // Upper bits kept as written; software is expected to zero them
  spinit_wordreg #(.RESET_VAL(`SPINIT_WORD_RESET)) u_w3 (
    .i_clk   (i_clk),
    .i_resetn(i_resetn),
    .i_we    (w3_we),
    .i_wdata (i_io_wdata),
    .o_q     (w3_q)
  );

  // Reset leaves auto EOI off
  spinit_wordreg #(.RESET_VAL(`SPINIT_W4_RESET)) u_w4 (
    .i_clk   (i_clk),
    .i_resetn(i_resetn),
    .i_we    (w4_we),
    .i_wdata (i_io_wdata),
    .o_q     (w4_q)
  );

  // Acknowledge vector and auto EOI pulse
  assign nxt_ack_vector = {vec_upper(w2_q),
                           i_resolver_level};
  assign aeoi_en        = ~w4_q[`SPINIT_W4_AEOI_BIT];
  assign nxt_aeoi       = i_ack_second && aeoi_en && in_oper;

  // Vector taken at the end of the second acknowledge cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ack_vector_ff <= `SPINIT_VECTOR_RESET;
    end else if (i_ack_second) begin
      ack_vector_ff <= nxt_ack_vector;
    end
  end

  // Pulse suppressed while a sequence is in progress
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      aeoi_ff <= `SPINIT_PULSE_RESET;
    end else begin
      aeoi_ff <= nxt_aeoi;
    end
  end

  // Configuration outputs
  assign o_init_busy      = !in_oper;
  assign o_level_trigger  = w1_q[`SPINIT_W1_LEVEL_BIT];
  assign o_vector_base    = vec_upper(w2_q);
  assign o_cascade_word   = w3_q;
  assign o_auto_eoi_en    = aeoi_en;
  assign o_full_nest_en   = w4_q[`SPINIT_W4_FNEST_BIT];

  // Acknowledge outputs
  assign o_ack_vector     = ack_vector_ff;
  assign o_auto_eoi_pulse = aeoi_ff;
endmodule : spinit_secondary_interrupt_unit
`default_nettype wire

// ### test/spinit_host.sv
// Host model issuing one-cycle port writes
`timescale 1ns/1ps
`default_nettype none
module spinit_host (
  input  wire logic       i_clk,
  output logic            o_io_wr,
  output logic [7:0]      o_io_addr,
  output logic [7:0]      o_io_wdata
);
  initial {o_io_wr, o_io_addr, o_io_wdata} = 17'h0;
  // Released bus shows the inverse value
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk);
    o_io_wr    <= 1'b1;
    o_io_addr  <= a;
    o_io_wdata <= d;
    @(posedge i_clk);
    o_io_wr    <= 1'b0;
    o_io_addr  <= ~a;
    o_io_wdata <= ~d;
  endtask : wr
endmodule : spinit_host
`default_nettype wire

// ### test/spinit_unit_sva.sv
// Port assertions of the initialization sequencer
`timescale 1ns/1ps
`default_nettype none
module spinit_chk (
  input wire logic       i_clk, i_resetn, i_io_wr, i_ack_second,
  input wire logic [7:0] i_io_addr, i_io_wdata, o_cascade_word, o_ack_vector,
  input wire logic [2:0] i_resolver_level,
  input wire logic [4:0] o_vector_base,
  input wire logic       o_init_busy, o_level_trigger, o_auto_eoi_en,
  input wire logic       o_full_nest_en, o_auto_eoi_pulse
);
  logic [1:0] n_ff;
  wire st = i_io_wr && i_io_addr == 8'hA0 && i_io_wdata[4];
  wire od = i_io_wr && i_io_addr == 8'hA1 && o_init_busy;
  always_ff @(posedge i_clk)
    n_ff <= (!i_resetn || st) ? 2'h0 : n_ff + 2'(od);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  seq_start_a: assert property (
    st |=> o_init_busy) else $error("start");
  stay_idle_a: assert property (
    !o_init_busy && !st |=> !o_init_busy) else $error("idle");
  trig_sel_a: assert property (
    st |=> o_level_trigger == $past(i_io_wdata[3])) else $error("trigger");
  vec_base_a: assert property (od && n_ff == 0 |=>
    o_vector_base == $past(i_io_wdata[7:3])) else $error("word two");
  casc_word_a: assert property (od && n_ff == 1 |=>
    o_cascade_word == $past(i_io_wdata)) else $error("word three");
  mode_word_a: assert property (
    od && n_ff == 2 |=> !o_init_busy &&
    o_full_nest_en == $past(i_io_wdata[4]) &&
    o_auto_eoi_en != $past(i_io_wdata[1])) else $error("word four");
  ack_vec_a: assert property (i_ack_second |=> o_ack_vector ==
    {$past(o_vector_base), $past(i_resolver_level)}) else $error("vector");
  eoi_pulse_a: assert property (o_auto_eoi_pulse ==
    $past(i_ack_second && o_auto_eoi_en && !o_init_busy)) else $error("eoi");
  cover property (od && n_ff == 2);
  cover property (o_auto_eoi_pulse);
  cover property (i_ack_second && o_init_busy);
endmodule : spinit_chk
bind spinit_secondary_interrupt_unit spinit_chk u_spinit_chk (.*);
`default_nettype wire

// ### test/spinit_secondary_interrupt_unit_test.sv
// Self-checking bench of the initialization sequencer
`timescale 1ns/1ps
`default_nettype none
module spinit_secondary_interrupt_unit_test;
  logic       i_clk = 1'b0, i_resetn = 1'b0, i_ack_second = 1'b0;
  logic [2:0] i_resolver_level = 3'h0;
  wire        i_io_wr;
  wire  [7:0] i_io_addr, i_io_wdata;
  logic       o_init_busy, o_level_trigger, o_auto_eoi_en, o_full_nest_en;
  logic       o_auto_eoi_pulse;
  logic [4:0] o_vector_base;
  logic [7:0] o_cascade_word, o_ack_vector;
  int         errors = 0, n_tests = 0;
  int         w1 = 0, w2 = 0, w3 = 0, w4 = 2, bz = 0, k;
  spinit_host u_spinit_host (.i_clk, .o_io_wr(i_io_wr),
    .o_io_addr(i_io_addr), .o_io_wdata(i_io_wdata));
  spinit_secondary_interrupt_unit u_spinit_secondary_interrupt_unit (.*);
  initial forever #12.5 i_clk = ~i_clk;
  task automatic test_done;
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [16:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_ack(input logic [8:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk_ack
  task automatic put(input int a, d);
    logic [16:0] got;
    logic [16:0] exp;
    u_spinit_host.wr(8'(a), 8'(d));
    if (a == 'hA0 && d[4]) begin
      w1 = d;
      bz = 1;
      k = 0;
    end else if (a == 'hA1 && bz == 1) begin
      k++;
      if (k == 1) w2 = d;
      if (k == 2) w3 = d;
      if (k == 3) w4 = d;
      bz = int'(k < 3);
    end
    #1;
    got = {o_init_busy, o_level_trigger, o_vector_base, o_cascade_word,
      o_auto_eoi_en, o_full_nest_en};
    exp = {bz[0], w1[3], w2[7:3], w3[7:0], !w4[1], w4[4]};
    chk(got, exp);
  endtask : put
  task automatic ak(input int l);
    logic [8:0] got;
    logic [8:0] exp;
    @(posedge i_clk);
    i_ack_second     <= 1'b1;
    i_resolver_level <= 3'(l);
    @(posedge i_clk);
    i_ack_second     <= 1'b0;
    i_resolver_level <= ~3'(l);
    #1;
    got = {o_ack_vector, o_auto_eoi_pulse};
    exp = {w2[7:3], 3'(l), !w4[1] && !bz[0]};
    chk_ack(got, exp);
  endtask : ak
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'h0ba0));
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    put('hA0, 'hE8);
    put('hA1, 'hFF);
    put('hA2, 'h1F);
    put('hA0, 'h10);
    put('hA1, 'h33);
    for (int i = 0; i < 6; i++) begin
      put('hA0, $urandom | 'h10);
      put('hA1, $urandom);
      ak($urandom);
      put('hA1, $urandom & 'h07);
      put('hA1, $urandom);
      ak($urandom);
    end
    test_done();
  end
endmodule : spinit_secondary_interrupt_unit_test
`default_nettype wire
